// file: hdl/uart_rx.sv
// Serial receive half with a four-word buffer and a Wishbone slave.
// Assumes RX_I is already synchronous to CLOCK_I and idles high.
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module uart_rx
    import uart_rx_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic RX_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic IRQ_O
);
    rx_ctrl_s uart_control_one; // Control bits
    logic [15:0] baud_divider_reg; // Oversample tick divisor
    logic [15:0] div_cnt_reg; // Tick down-counter
    logic tick; // One oversample tick
    rx_state_e state_reg; // Receive state
    logic [3:0] os_cnt_reg; // Position inside bit
    logic [3:0] bit_idx_reg; // Bit index in word
    logic [8:0] receive_shift_reg; // Assembled bits
    logic samp_a_reg; // First centre sample
    logic samp_b_reg; // Second centre sample
    logic rx_prev_reg; // Line at previous tick
    logic frame_noise_reg; // Noise seen in frame
    logic stop_bad_reg; // First stop was low
    rx_entry_s receive_data_fifo [0:3]; // Word buffer
    logic [1:0] wr_ptr_reg; // Buffer write slot
    logic [1:0] rd_ptr_reg; // Buffer read slot
    logic [2:0] count_reg; // Words held
    logic receive_data_available_flag; // Data available
    logic overrun_flag; // Overrun
    logic noise_flag; // Noise
    logic status_seen_reg; // Status read armed
    logic ack_reg; // Bus answer
    logic [31:0] dat_reg; // Read data
    logic irq_reg; // Interrupt pulse
    logic vote; // Majority result
    logic vote_noisy; // Samples disagreed
    logic [3:0] nbits; // Bits per word incl. parity
    logic finish; // Frame ends this tick
    logic framing_error_flag_final; // Frame stop error
    logic parity_error_flag_calc; // Parity mismatch
    logic [8:0] word_calc; // Word without parity bit
    logic push; // Store word
    logic overrun_evt; // Word lost to full buffer
    logic bus_req; // New bus request
    logic rd_status; // Status read taken
    logic rd_data; // Data read taken
    logic pop; // Buffer read
    logic seq_clear; // Status then data sequence
    logic [2:0] count_next; // Words after this cycle
    logic active; // Receiver may run

    // Bus request is taken once per access; ack closes it
    assign bus_req = CYC_I && STB_I && !ack_reg;
    assign rd_status = bus_req && !WE_I && (ADR_I == `OFS_STATUS);
    assign rd_data = bus_req && !WE_I && (ADR_I == `OFS_DATA);
    assign pop = rd_data && (count_reg != 3'h0);
    assign seq_clear = rd_data && status_seen_reg;
    assign active = uart_control_one.uart_en && uart_control_one.rx_en;

    // Majority of three centre samples
    assign vote = (samp_a_reg & samp_b_reg) | (samp_a_reg & RX_I) | (samp_b_reg & RX_I);
    assign vote_noisy = !(samp_a_reg == samp_b_reg && samp_b_reg == RX_I);

    // Word length; parity takes the top bit of the word
    assign nbits = uart_control_one.nine_bit ? `BITS_NINE : `BITS_EIGHT;

    // Frame ends at the centre of the last stop bit
    always_comb
    begin
        finish = 1'b0;
        framing_error_flag_final = 1'b0;
        if (tick && active && os_cnt_reg == `OS_VOTE)
        begin
            // Two stop_count_select need both high; break ends after set length
            if (state_reg == ST_STOP1 && !uart_control_one.two_stop)
            begin
                finish = 1'b1;
                framing_error_flag_final = !vote;
            end
            else if (state_reg == ST_STOP2)
            begin
                finish = 1'b1;
                framing_error_flag_final = stop_bad_reg || !vote;
            end
        end
    end

    // Parity check and removal of the parity bit
    always_comb
    begin
        word_calc = receive_shift_reg;
        parity_error_flag_calc = 1'b0;
        if (uart_control_one.par_en)
        begin
            // Xor of data and parity: 0 for even, 1 for odd
            parity_error_flag_calc = (^receive_shift_reg) ^ uart_control_one.par_odd;
            word_calc[nbits - 4'h1] = 1'b0;
        end
    end

    // Full buffer keeps its contents and drops the new word
    assign push = finish && (count_reg != `FIFO_DEPTH);
    assign overrun_evt = finish && (count_reg == `FIFO_DEPTH);

    always_comb
    begin
        count_next = count_reg;
        if (push && !pop)
        begin
            count_next = count_reg + 3'h1;
        end
        else if (pop && !push)
        begin
            count_next = count_reg - 3'h1;
        end
    end

    // Oversample tick generator
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            div_cnt_reg <= 16'h0000;
        end
        else if (CE_I)
        begin
            // Reload on tick; tick period is divisor plus one clocks
            if (div_cnt_reg == 16'h0000)
            begin
                div_cnt_reg <= baud_divider_reg;
            end
            else
            begin
                div_cnt_reg <= div_cnt_reg - 16'h0001;
            end
        end
    end
    assign tick = CE_I && (div_cnt_reg == 16'h0000);

    // Control and divider registers
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            uart_control_one <= `RST_CONTROL;
            baud_divider_reg <= `RST_DIVIDER;
        end
        else if (CE_I)
        begin
            if (bus_req && WE_I && ADR_I == `OFS_CONTROL && SEL_I[0])
            begin
                uart_control_one <= rx_ctrl_s'(DAT_I[6:0]);
                // Disable drops the receiver enable as well
                if (!DAT_I[`CTL_UART_EN])
                begin
                    uart_control_one.rx_en <= 1'b0;
                end
            end
            if (bus_req && WE_I && ADR_I == `OFS_DIVIDER)
            begin
                // Byte lanes honoured per half
                if (SEL_I[0])
                begin
                    baud_divider_reg[7:0] <= DAT_I[7:0];
                end
                if (SEL_I[1])
                begin
                    baud_divider_reg[15:8] <= DAT_I[15:8];
                end
            end
        end
    end

    // Receive state machine, advanced on oversample ticks
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_reg <= ST_IDLE;
            os_cnt_reg <= 4'h0;
            bit_idx_reg <= 4'h0;
            receive_shift_reg <= 9'h000;
            rx_prev_reg <= 1'b1;
            frame_noise_reg <= 1'b0;
            stop_bad_reg <= 1'b0;
            samp_a_reg <= 1'b1;
            samp_b_reg <= 1'b1;
        end
        else if (CE_I && !active)
        begin
            // Disabled: reception suspended at once
            state_reg <= ST_IDLE;
            rx_prev_reg <= 1'b1;
            os_cnt_reg <= 4'h0;
        end
        else if (tick)
        begin
            rx_prev_reg <= RX_I;
            os_cnt_reg <= os_cnt_reg + 4'h1;
            if (os_cnt_reg == `OS_SAMPLE_A)
            begin
                samp_a_reg <= RX_I;
            end
            if (os_cnt_reg == `OS_SAMPLE_B)
            begin
                samp_b_reg <= RX_I;
            end
            if (os_cnt_reg == `OS_VOTE && vote_noisy && state_reg != ST_IDLE)
            begin
                frame_noise_reg <= 1'b1;
            end
            case (state_reg)
                ST_IDLE:
                begin
                    // Only a high-to-low step starts a frame
                    os_cnt_reg <= 4'h0;
                    if (rx_prev_reg && !RX_I)
                    begin
                        state_reg <= ST_START;
                        os_cnt_reg <= 4'h1;
                        receive_shift_reg <= 9'h000;
                        bit_idx_reg <= 4'h0;
                        frame_noise_reg <= 1'b0;
                        stop_bad_reg <= 1'b0;
                    end
                end
                ST_START:
                begin
                    // Glitch shorter than half a bit is rejected
                    if (os_cnt_reg == `OS_VOTE && vote)
                    begin
                        state_reg <= ST_IDLE;
                    end
                    else if (os_cnt_reg == `OS_LAST)
                    begin
                        state_reg <= ST_BITS;
                    end
                end
                ST_BITS:
                begin
                    if (os_cnt_reg == `OS_VOTE)
                    begin
                        receive_shift_reg[bit_idx_reg] <= vote;
                    end
                    if (os_cnt_reg == `OS_LAST)
                    begin
                        // Shifter steps once per bit time
                        if (bit_idx_reg == nbits - 4'h1)
                        begin
                            state_reg <= ST_STOP1;
                        end
                        else
                        begin
                            bit_idx_reg <= bit_idx_reg + 4'h1;
                        end
                    end
                end
                ST_STOP1:
                begin
                    if (os_cnt_reg == `OS_VOTE)
                    begin
                        stop_bad_reg <= !vote;
                    end
                    if (finish)
                    begin
                        // A low line is never taken as the next start
                        state_reg <= framing_error_flag_final ? ST_WAIT : ST_IDLE;
                    end
                    else if (os_cnt_reg == `OS_LAST)
                    begin
                        state_reg <= ST_STOP2;
                    end
                end
                ST_STOP2:
                begin
                    if (finish)
                    begin
                        state_reg <= framing_error_flag_final ? ST_WAIT : ST_IDLE;
                    end
                end
                ST_WAIT:
                begin
                    // Hold off until the line returns high
                    os_cnt_reg <= 4'h0;
                    if (RX_I)
                    begin
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Word buffer storage; each word carries its own flags
    always_ff @(posedge CLOCK_I)
    begin
        if (CE_I && push)
        begin
            receive_data_fifo[wr_ptr_reg] <= '{framing: framing_error_flag_final, parity: parity_error_flag_calc,
                word: word_calc};
        end
    end

    // Buffer pointers and fill count
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            wr_ptr_reg <= 2'h0;
            rd_ptr_reg <= 2'h0;
            count_reg <= 3'h0;
        end
        else if (CE_I)
        begin
            if (!uart_control_one.uart_en)
            begin
                // Residual words are discarded
                wr_ptr_reg <= 2'h0;
                rd_ptr_reg <= 2'h0;
                count_reg <= 3'h0;
            end
            else
            begin
                if (push)
                begin
                    wr_ptr_reg <= wr_ptr_reg + 2'h1;
                end
                if (pop)
                begin
                    rd_ptr_reg <= rd_ptr_reg + 2'h1;
                end
                count_reg <= count_next;
            end
        end
    end

    // Sticky receive flags; a new event wins over a clear
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            receive_data_available_flag <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            status_seen_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            if (!uart_control_one.uart_en)
            begin
                receive_data_available_flag <= 1'b0;
                overrun_flag <= 1'b0;
                noise_flag <= 1'b0;
                status_seen_reg <= 1'b0;
            end
            else
            begin
                // Status read arms, data read consumes the arming
                if (rd_status)
                begin
                    status_seen_reg <= 1'b1;
                end
                else if (rd_data)
                begin
                    status_seen_reg <= 1'b0;
                end
                if (push)
                begin
                    receive_data_available_flag <= 1'b1;
                end
                else if (seq_clear && count_next == 3'h0)
                begin
                    receive_data_available_flag <= 1'b0;
                end
                if (overrun_evt)
                begin
                    overrun_flag <= 1'b1;
                end
                else if (seq_clear)
                begin
                    overrun_flag <= 1'b0;
                end
                // Stop bit votes at the push tick, so count its noise too
                if (push && (frame_noise_reg || vote_noisy))
                begin
                    noise_flag <= 1'b1;
                end
                else if (seq_clear)
                begin
                    noise_flag <= 1'b0;
                end
            end
        end
    end

    // Interrupt pulse on transfer or overrun; noise adds none
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            irq_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            irq_reg <= uart_control_one.receive_interrupt_enable && (push || overrun_evt);
        end
    end

    // Wishbone answer: ack one cycle after the request, then drop
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end
        else if (CE_I)
        begin
            ack_reg <= bus_req;
            if (bus_req && !WE_I)
            begin
                case (ADR_I)
                    `OFS_CONTROL:
                    begin
                        dat_reg <= {25'h0, uart_control_one};
                    end
                    `OFS_STATUS:
                    begin
                        // Head word flags shown before its data is read
                        dat_reg <= {25'h0,
                            receive_data_fifo[rd_ptr_reg].word[8] && count_reg != 3'h0,
                            (state_reg == ST_IDLE) || (state_reg == ST_WAIT),
                            receive_data_fifo[rd_ptr_reg].parity && count_reg != 3'h0,
                            receive_data_fifo[rd_ptr_reg].framing && count_reg != 3'h0,
                            noise_flag, overrun_flag,
                            receive_data_available_flag};
                    end
                    `OFS_DATA:
                    begin
                        // Empty buffer reads as zero
                        dat_reg <= (count_reg != 3'h0) ?
                            {24'h0, receive_data_fifo[rd_ptr_reg].word[7:0]} : 32'h0;
                    end
                    `OFS_DIVIDER:
                    begin
                        dat_reg <= {16'h0, baud_divider_reg};
                    end
                    default:
                    begin
                        // Unmapped offsets read zero and still ack
                        dat_reg <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign ACK_O = ack_reg;
    assign DAT_O = dat_reg;
    assign IRQ_O = irq_reg;
endmodule

`default_nettype wire

// file: hdl/uart_rx_params.svh
// Constants for the serial receive block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package only; the receive module uses its macros without including it.
// Notes on behaviour
// - Nine-bit select gives 9-bit words, ninth bit kept unless parity enabled (then cleared).
// - Recovery at sixteen times baud, shifter per bit.
// - Three samples majority-voted decide each bit.
// - Bits enter shift register least significant first.
// - After stop sampled, word moves into buffer.
// - Buffer holds four words, fifth still shifts.
// - Fifth word into full buffer: overrun, discarded.
// - Receiver enable starts the start bit search.
// - Data flag set on transfer; interrupt if enabled.
// - Overrun requests interrupt when enable set.
// - Data flag clears on status then data read of the last word.
// - Overrun clears on status then data read.
// - Break loads zeros, sets data, framing, idle.
// - After bad stop, wait high before hunting.
// - Idle low from start until stop read.
// - Noise still transfers word, flag with data.
// - Noise clears on status then data read.
// - Low stop bit sets framing; both stop_count_select checked.
// - Framing and parity stored per word, not reset; masked to zero while buffer empty.
// - Parity checked against odd/even only when enabled.
// - Disable empties buffer, clears flags, sets idle.
// - Parity type and stop count independently selectable.
`ifndef UART_RX_PARAMS_SVH
`define UART_RX_PARAMS_SVH

// Register byte offsets
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h4
`define OFS_DATA 4'h8
`define OFS_DIVIDER 4'hC

// Control field positions
`define CTL_UART_EN 0
`define CTL_RX_EN 1
`define CTL_NINE_BIT 2
`define CTL_PAR_EN 3
`define CTL_PAR_ODD 4
`define CTL_TWO_STOP 5
`define CTL_RIE 6

// Status field positions
`define STA_AVAIL 0
`define STA_OVERRUN 1
`define STA_NOISE 2
`define STA_FRAMING 3
`define STA_PARITY 4
`define STA_IDLE 5
`define STA_NINTH 6

// Reset values
`define RST_CONTROL 7'h00
`define RST_DIVIDER 16'h001A

// Oversampling: ticks per bit and sample points
`define OS_LAST 4'hF
`define OS_SAMPLE_A 4'h7
`define OS_SAMPLE_B 4'h8
`define OS_VOTE 4'h9

// Buffer depth and word lengths
`define FIFO_DEPTH 3'h4
`define BITS_EIGHT 4'h8
`define BITS_NINE 4'h9

`endif

// file: hdl/uart_rx_pkg.sv
// Types shared by the serial receive block.
// Assumes the constants header sits beside it on the include path.
package uart_rx_pkg;
    `include "uart_rx_params.svh"

    // Receive state machine
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_BITS = 3'b010,
        ST_STOP1 = 3'b011,
        ST_STOP2 = 3'b100,
        ST_WAIT = 3'b101
    } rx_state_e;

    // One buffered word with its own error flags
    typedef struct packed {
        logic framing;
        logic parity;
        logic [8:0] word;
    } rx_entry_s;

    // Software control bits
    typedef struct packed {
        logic receive_interrupt_enable;
        logic two_stop;
        logic par_odd;
        logic par_en;
        logic nine_bit;
        logic rx_en;
        logic uart_en;
    } rx_ctrl_s;
endpackage

// file: dv/uart_rx_properties.sv
// Port-level checker for the serial receive block, bound below.
// Assumes the bench holds CE_I high around bus accesses.
`timescale 1ns/1ps
`default_nettype none

module uart_rx_properties (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic RX_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic IRQ_O
);
    logic [15:0] div_reg; // Divider as last written
    int high_reg; // Clocks the line has stayed high
    int limit; // Longest high run before a store can happen
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    // Twelve and a half bit times cover a whole frame after its start bit
    assign limit = 200 * (int'(div_reg) + 1);

    // Shadow the divider, byte by byte as the slave does
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
            div_reg <= 16'h001A;
        else if (CE_I && CYC_I && STB_I && WE_I && !ACK_O && ADR_I == 4'hC)
        begin
            if (SEL_I[0])
                div_reg[7:0] <= DAT_I[7:0];
            if (SEL_I[1])
                div_reg[15:8] <= DAT_I[15:8];
        end
    end

    // Count high clocks, saturating so it never wraps
    always_ff @(posedge CLOCK_I or posedge RST_I)
    begin
        if (RST_I)
            high_reg <= 0;
        else if (!RX_I)
            high_reg <= 0;
        else if (CE_I && high_reg <= limit)
            high_reg <= high_reg + 1;
    end

    sequence s_taken;
        CYC_I && STB_I && !ACK_O && CE_I;
    endsequence
    sequence s_answer;
        ACK_O ##1 !ACK_O;
    endsequence

    ack_answer_a: assert property (s_taken |=> s_answer)
        else $error("ack not a single pulse after request");
    no_stray_ack_a: assert property (CE_I && !(CYC_I && STB_I) |=> !ACK_O)
        else $error("ack without request");
    unmapped_zero_a: assert property (s_taken and !WE_I && ADR_I[1:0] != 2'h0 |=> DAT_O == 32'h0)
        else $error("unmapped read not zero");
    div_readback_a: assert property (s_taken and !WE_I && ADR_I == 4'hC |=> DAT_O[15:0] == div_reg)
        else $error("divider readback wrong");
    data_width_a: assert property (s_taken and !WE_I && ADR_I == 4'h8 |=> DAT_O[31:8] == 24'h0)
        else $error("data read wider than a byte");
    irq_pulse_a: assert property (IRQ_O && CE_I |=> !IRQ_O)
        else $error("interrupt longer than one clock");
    outputs_freeze_a: assert property (!CE_I |=> $stable(ACK_O) && $stable(IRQ_O) && $stable(DAT_O))
        else $error("outputs moved with clock enable low");
    irq_frame_a: assert property ($rose(IRQ_O) |-> high_reg <= limit)
        else $error("interrupt with no frame on the line");
endmodule

bind uart_rx uart_rx_properties u_props (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I),
    .RX_I(RX_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
    .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ_O(IRQ_O));

`default_nettype wire

// file: dv/serial_tx_model.sv
// Remote transmitter model driving the receive line.
// Assumes one oversample tick per clock, so a bit is BIT_CLKS clocks.
`timescale 1ns/1ps
`default_nettype none

module serial_tx_model #(parameter int BIT_CLKS = 16) (
    input wire logic clk_i,
    output logic line_o
);
    initial line_o = 1'b1; // Idle marking level
    logic noisy = 1'b0; // Flip one centre sample of the first bit

    // Start bit, then n bits LSB first; caller supplies stop levels
    task automatic send(input logic [19:0] bits, input int n);
        int i;
        int k;
        for (i = -1; i < n; i++)
        begin
            for (k = 0; k < BIT_CLKS; k++)
            begin
                @(posedge clk_i);
                line_o <= (i < 0) ? 1'b0 : bits[i] ^ (noisy && i == 0 && k == 8);
            end
        end
        // Always end high so a broken frame still finds a stop level
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask
endmodule

`default_nettype wire

// file: dv/uart_rx_bench.sv
// Self-checking bench for the serial receive block.
// Assumes the bound checker; divider set to 0 so a bit is 16 clocks.
`timescale 1ns/1ps
`default_nettype none

module uart_rx_bench import uart_rx_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic rx;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    int n_fail = 0;
    int samples_checked = 0;
    int irq_n = 0; // Interrupt pulses seen

    uart_rx DUT (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .RX_I(rx), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
        .IRQ_O(irq));
    serial_tx_model #(.BIT_CLKS(16)) tx (.clk_i(clk), .line_o(rx));

    // 50 MHz clock
    initial forever #10 clk = ~clk;

    // Pulses are one clock wide, so count them at every edge
    always @(posedge clk)
        if (irq === 1'b1)
            irq_n++;

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Classic cycle; hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(name, exp, q);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    // Reset values, read-only status, unmapped place, clock enable
    task automatic t_regs;
        rd(4'h0, 32'h0, "control");
        rd(4'hC, 32'h1A, "divider");
        rd(4'h4, 32'h20, "status");
        rd(4'h1, 32'h0, "unmapped");
        wr(4'h4, 32'hFF);
        rd(4'h4, 32'h20, "status write ignored");
        wr(4'hC, 32'h0);
        rd(4'hC, 32'h0, "divider");
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        $display("test regs done");
    endtask

    // One frame: flags are read before the word, then the word
    task automatic one_frame(input rx_ctrl_s ctl, input logic [19:0] bits, input int n,
        input logic [31:0] st, input logic [31:0] dt);
        int n0;
        wr(4'h0, {25'h0, ctl});
        n0 = irq_n;
        tx.send(bits, n);
        check("irq count", 32'd1, irq_n - n0);
        rd(4'h4, st, "status with word");
        rd(4'h8, dt, "data");
        rd(4'h4, 32'h20, "status drained");
        $display("test frame %h done", bits);
    endtask

    // Five words into four places, then drain in order
    task automatic t_overrun;
        int i;
        int n0;
        wr(4'h0, 32'h43);
        n0 = irq_n;
        for (i = 0; i < 5; i++)
            tx.send(20'h111 + 20'(i), 9);
        check("irq count", 32'd5, irq_n - n0);
        for (i = 0; i < 4; i++)
        begin
            rd(4'h4, (i == 0) ? 32'h23 : 32'h21, "status overrun");
            rd(4'h8, 32'h11 + 32'(i), "fifo word");
        end
        rd(4'h4, 32'h20, "status empty");
        $display("test overrun done");
    endtask

    // Receiver off, interrupt off, then uart disable
    task automatic t_disable;
        int n0;
        wr(4'h0, 32'h01);
        tx.send(20'h1A5, 9);
        rd(4'h4, 32'h20, "receiver off");
        wr(4'h0, 32'h03);
        n0 = irq_n;
        tx.send(20'h15A, 9);
        check("irq masked", 32'd0, irq_n - n0);
        rd(4'h4, 32'h21, "status");
        wr(4'h0, 32'h42);
        rd(4'h4, 32'h20, "status disabled");
        rd(4'h8, 32'h0, "data disabled");
        rd(4'h0, 32'h40, "control disabled");
        $display("test disable done");
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        one_frame(7'h43, 20'h1A5, 9, 32'h21, 32'hA5);
        one_frame(7'h47, 20'h3C3, 10, 32'h61, 32'hC3);
        one_frame(7'h5B, 20'h135, 9, 32'h31, 32'h35);
        one_frame(7'h4B, 20'h135, 9, 32'h21, 32'h35);
        one_frame(7'h63, 20'h13C, 10, 32'h29, 32'h3C);
        one_frame(7'h63, 20'h33C, 10, 32'h21, 32'h3C);
        tx.noisy <= 1'b1;
        one_frame(7'h43, 20'h1A5, 9, 32'h25, 32'hA5);
        tx.noisy <= 1'b0;
        one_frame(7'h43, 20'h0, 20, 32'h29, 32'h0);
        t_overrun();
        t_disable();
        summarize();
    end

    // Whole run needs about 2800 clocks
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        summarize();
    end
endmodule

`default_nettype wire
